// ==== common/lock_cmd_pkg.sv ====
package lock_cmd_pkg;

   // Command opcodes, one byte each.
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_BLOCK_LOCK = 8'h36;
   localparam logic [7:0] OP_BLOCK_UNLOCK = 8'h39;
   localparam logic [7:0] OP_LOCK_STATUS = 8'h3d;
   localparam logic [7:0] OP_UNIQUE_ID = 8'h4b;
   localparam logic [7:0] OP_PARAM_TABLE = 8'h5a;
   localparam logic [7:0] OP_RESET_ARM = 8'h66;
   localparam logic [7:0] OP_CHIP_LOCK = 8'h7e;
   localparam logic [7:0] OP_CHIP_UNLOCK = 8'h98;
   localparam logic [7:0] OP_RESET_FIRE = 8'h99;
   localparam logic [7:0] OP_NOP = 8'h00;

   // Array geometry of a 16-Mbit part.
   localparam int ADDR_W = 21;
   localparam int BLOCK_HI = 20;
   localparam int BLOCK_LO = 16;
   localparam int SECTOR_HI = 15;
   localparam int SECTOR_LO = 12;
   localparam int NUM_BLOCKS = 32;
   localparam int SECTORS_PER_BLOCK = 16;
   localparam int BLOCK_IDX_W = 5;
   localparam int SECTOR_IDX_W = 4;
   localparam logic [4:0] EDGE_BLOCK_LOW = 5'h00;
   localparam logic [4:0] EDGE_BLOCK_HIGH = 5'h1f;
   localparam logic LOCK_RESET_VAL = 1'b1;

   // Frame byte positions: command bytes expected and first data-out byte.
   localparam logic [3:0] CHIP_CMD_BYTES = 4'h1;
   localparam logic [3:0] BLOCK_CMD_BYTES = 4'h4;
   localparam logic [3:0] STATUS_DATA_BYTE = 4'h4;
   localparam logic [3:0] UID_DATA_BYTE = 4'h5;
   localparam logic [3:0] TABLE_DATA_BYTE = 4'h5;
   localparam logic [3:0] NO_DATA_BYTE = 4'hf;
   localparam logic [3:0] BYTE_CNT_MAX = 4'hf;

   // Data-line drive patterns; low enables the driver.
   localparam logic [3:0] OE_N_IDLE = 4'hf;
   localparam logic [3:0] OE_N_SINGLE = 4'hd;
   localparam logic [3:0] OE_N_QUAD = 4'h0;
   localparam logic [6:0] STATUS_PAD = 7'h00;
   localparam logic [7:0] TABLE_BLANK = 8'hff;

   // Timing.
   localparam int CLK_PERIOD_NS = 25;
   localparam int RESET_LOW_MIN_US = 10;
   localparam int RESET_LOW_MIN_CYCLES =
      (RESET_LOW_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : lock_cmd_pkg

// ==== common/lock_mem_if.sv ====
`timescale 1ns/100ps
interface lock_mem_if;
   logic wr_en;
   logic [lock_cmd_pkg::BLOCK_IDX_W-1:0] wr_idx;
   logic [lock_cmd_pkg::SECTORS_PER_BLOCK-1:0] wr_mask;
   logic wr_val;
   logic fill_en;
   logic fill_val;
   logic [lock_cmd_pkg::BLOCK_IDX_W-1:0] rd_a_idx;
   logic [lock_cmd_pkg::BLOCK_IDX_W-1:0] rd_b_idx;
   logic [lock_cmd_pkg::SECTORS_PER_BLOCK-1:0] rd_a_data;
   logic [lock_cmd_pkg::SECTORS_PER_BLOCK-1:0] rd_b_data;

   modport ctrl (output wr_en, wr_idx, wr_mask, wr_val, fill_en, fill_val, rd_a_idx,
                 rd_b_idx, input rd_a_data, rd_b_data);
   modport store (input wr_en, wr_idx, wr_mask, wr_val, fill_en, fill_val, rd_a_idx,
                  rd_b_idx, output rd_a_data, rd_b_data);
endinterface : lock_mem_if

// ==== rtl/lock_store.sv ====
`timescale 1ns/100ps
module lock_store #(
   parameter int DEPTH = lock_cmd_pkg::NUM_BLOCKS,
   parameter int WIDTH = lock_cmd_pkg::SECTORS_PER_BLOCK
) (
   input wire logic clk,
   input wire logic reset,
   lock_mem_if.store m
);

   initial begin
      if (DEPTH != lock_cmd_pkg::NUM_BLOCKS || WIDTH != lock_cmd_pkg::SECTORS_PER_BLOCK) begin
         $error("lock_store geometry must match the lock memory interface.");
      end
   end

   logic [WIDTH-1:0] word_q [DEPTH];

   // A fill beats a single write so a reset never leaves a stray unlocked word.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < DEPTH; i++) begin
            word_q[i] <= {WIDTH{lock_cmd_pkg::LOCK_RESET_VAL}};
         end
      end else if (m.fill_en) begin
         for (int i = 0; i < DEPTH; i++) begin
            word_q[i] <= {WIDTH{m.fill_val}};
         end
      end else if (m.wr_en) begin
         word_q[m.wr_idx] <= (word_q[m.wr_idx] & ~m.wr_mask) | (m.wr_mask & {WIDTH{m.wr_val}});
      end
   end

   // Registered read ports; data lags the index by one clock.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         m.rd_a_data <= {WIDTH{lock_cmd_pkg::LOCK_RESET_VAL}};
         m.rd_b_data <= {WIDTH{lock_cmd_pkg::LOCK_RESET_VAL}};
      end else begin
         m.rd_a_data <= word_q[m.rd_a_idx];
         m.rd_b_data <= word_q[m.rd_b_idx];
      end
   end

   fill_restore_a: assert property (@(posedge clk) disable iff (reset)
      (m.fill_en && m.fill_val) |=> (&word_q[0] && &word_q[DEPTH-1]))
      else $error("Lock fill did not set every lock bit.");

endmodule : lock_store

// ==== rtl/flash_lock_cmd.sv ====
`timescale 1ns/100ps
module flash_lock_cmd #(
   // The default identifier value is arbitrary; each part gets its own.
   parameter logic [127:0] UNIQUE_ID = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic sel_n_pin,
   input wire logic sclk_pin,
   input wire logic [3:0] sio_in,
   input wire logic reset_n_pin,
   output logic [3:0] sio_out,
   output logic [3:0] sio_oe_n,
   input wire logic four_line_command_mode,
   input wire logic protect_scheme_select,
   input wire logic complement_protect_bit,
   input wire logic [4:0] block_protect_bits,
   input wire logic busy_flag,
   input wire logic pe_req,
   input wire logic [lock_cmd_pkg::ADDR_W-1:0] pe_addr,
   output logic pe_ack,
   output logic pe_ok,
   output logic write_latch_bit,
   output logic soft_reset,
   output logic op_abort
);

   localparam int PIN_CNT_W = $clog2(lock_cmd_pkg::RESET_LOW_MIN_CYCLES + 1);
   localparam logic [PIN_CNT_W-1:0] PIN_CNT_LAST =
      PIN_CNT_W'(lock_cmd_pkg::RESET_LOW_MIN_CYCLES - 1);

   initial begin
      if (lock_cmd_pkg::RESET_LOW_MIN_CYCLES < 2) begin
         $error("Reset pin low time must span at least two clocks.");
      end
   end

   // Gives the first data-out byte of a read command, or none.
   function automatic logic [3:0] data_start(input logic [7:0] op);
      case (op)
         lock_cmd_pkg::OP_LOCK_STATUS: data_start = lock_cmd_pkg::STATUS_DATA_BYTE;
         lock_cmd_pkg::OP_UNIQUE_ID: data_start = lock_cmd_pkg::UID_DATA_BYTE;
         lock_cmd_pkg::OP_PARAM_TABLE: data_start = lock_cmd_pkg::TABLE_DATA_BYTE;
         default: data_start = lock_cmd_pkg::NO_DATA_BYTE;
      endcase
   endfunction : data_start

   // Only the outer blocks are sector-granular; the rest lock whole.
   function automatic logic [15:0] lock_mask(input logic [23:0] a);
      if (a[lock_cmd_pkg::BLOCK_HI:lock_cmd_pkg::BLOCK_LO] == lock_cmd_pkg::EDGE_BLOCK_LOW ||
          a[lock_cmd_pkg::BLOCK_HI:lock_cmd_pkg::BLOCK_LO] == lock_cmd_pkg::EDGE_BLOCK_HIGH) begin
         lock_mask = 16'h0001 << a[lock_cmd_pkg::SECTOR_HI:lock_cmd_pkg::SECTOR_LO];
      end else begin
         lock_mask = 16'hffff;
      end
   endfunction : lock_mask

   // Top-down protected range: 2^(bp-1) blocks, whole array from 6 up; complement inverts.
   function automatic logic bp_protects(input logic cmp, input logic [4:0] bp,
                                        input logic [4:0] blk);
      logic [5:0] count;
      count = 6'h00;
      if (bp > 5'h05) begin
         count = 6'h20;
      end else if (bp != 5'h00) begin
         count = 6'h01 << (bp - 5'h01);
      end
      bp_protects = cmp ^ ({1'b0, blk} >= (6'h20 - count));
   endfunction : bp_protects

   // Table header bytes; the rest of the table reads blank.
   function automatic logic [7:0] table_byte(input logic [7:0] a);
      case (a)
         8'h00: table_byte = 8'h53;
         8'h01: table_byte = 8'h46;
         8'h02: table_byte = 8'h44;
         8'h03: table_byte = 8'h50;
         8'h04: table_byte = 8'h00;
         8'h05: table_byte = 8'h01;
         8'h06: table_byte = 8'h01;
         default: table_byte = lock_cmd_pkg::TABLE_BLANK;
      endcase
   endfunction : table_byte

   lock_mem_if m ();

   lock_store #(
      .DEPTH(lock_cmd_pkg::NUM_BLOCKS),
      .WIDTH(lock_cmd_pkg::SECTORS_PER_BLOCK)
   ) u_store (
      .clk(clk),
      .reset(reset),
      .m(m.store)
   );

   // Pins are asynchronous to clk; meta_q is read only by sync_q.
   logic [6:0] meta_q;
   logic [6:0] sync_q;
   logic sel_prev_q;
   logic sclk_prev_q;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         meta_q <= 7'h60;
         sync_q <= 7'h60;
         sel_prev_q <= 1'b1;
         sclk_prev_q <= 1'b0;
      end else begin
         meta_q <= {reset_n_pin, sel_n_pin, sclk_pin, sio_in};
         sync_q <= meta_q;
         sel_prev_q <= sync_q[5];
         sclk_prev_q <= sync_q[4];
      end
   end

   logic pin_s;
   logic frame;
   logic sck_rise;
   logic sck_fall;
   logic frame_end;
   assign pin_s = sync_q[6];
   assign frame = !sync_q[5] && pin_s;
   assign sck_rise = sync_q[4] && !sclk_prev_q;
   assign sck_fall = !sync_q[4] && sclk_prev_q;

   logic wipe_q;
   logic [2:0] bit_cnt_q;
   logic [3:0] byte_cnt_q;
   logic [7:0] in_sh_q;
   logic [7:0] cmd_q;
   logic [23:0] addr_q;
   logic [7:0] in_byte;
   logic [3:0] bit_sum;
   logic [3:0] step;
   assign frame_end = sync_q[5] && !sel_prev_q && pin_s && !wipe_q;
   assign step = four_line_command_mode ? 4'h4 : 4'h1;
   assign bit_sum = {1'b0, bit_cnt_q} + step;
   assign in_byte = four_line_command_mode ? {in_sh_q[3:0], sync_q[3:0]}
                                           : {in_sh_q[6:0], sync_q[0]};

   // Input shifter: one or four bits per rising serial clock edge.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         bit_cnt_q <= 3'h0;
         byte_cnt_q <= 4'h0;
         in_sh_q <= 8'h00;
         cmd_q <= lock_cmd_pkg::OP_NOP;
         addr_q <= 24'h000000;
      end else if (wipe_q || !frame) begin
         bit_cnt_q <= 3'h0;
         byte_cnt_q <= 4'h0;
      end else if (sck_rise) begin
         bit_cnt_q <= bit_sum[2:0];
         in_sh_q <= in_byte;
         if (bit_sum[3]) begin
            if (byte_cnt_q != lock_cmd_pkg::BYTE_CNT_MAX) begin
               byte_cnt_q <= 4'(byte_cnt_q + 4'h1);
            end
            if (byte_cnt_q == 4'h0) begin
               cmd_q <= in_byte;
            end else if (byte_cnt_q < 4'h4) begin
               addr_q <= {addr_q[15:0], in_byte};
            end
         end
      end
   end

   // Frame-end decode: lock commands need the latch and a whole number of bytes.
   logic boundary;
   logic block_go;
   logic chip_go;
   logic fire_go;
   logic wel_q;
   logic arm_q;
   assign boundary = bit_cnt_q == 3'h0;
   assign block_go = frame_end && boundary && wel_q &&
      byte_cnt_q == lock_cmd_pkg::BLOCK_CMD_BYTES &&
      (cmd_q == lock_cmd_pkg::OP_BLOCK_LOCK || cmd_q == lock_cmd_pkg::OP_BLOCK_UNLOCK);
   assign chip_go = frame_end && boundary && wel_q &&
      byte_cnt_q == lock_cmd_pkg::CHIP_CMD_BYTES &&
      (cmd_q == lock_cmd_pkg::OP_CHIP_LOCK || cmd_q == lock_cmd_pkg::OP_CHIP_UNLOCK);
   assign fire_go = frame_end && boundary && arm_q &&
      byte_cnt_q == lock_cmd_pkg::CHIP_CMD_BYTES && cmd_q == lock_cmd_pkg::OP_RESET_FIRE;

   // Lock memory control; a wipe fills locked and outranks everything else.
   assign m.wr_en = block_go;
   assign m.wr_idx = addr_q[lock_cmd_pkg::BLOCK_HI:lock_cmd_pkg::BLOCK_LO];
   assign m.wr_mask = lock_mask(addr_q);
   assign m.wr_val = cmd_q == lock_cmd_pkg::OP_BLOCK_LOCK;
   assign m.fill_en = chip_go || wipe_q;
   assign m.fill_val = wipe_q || cmd_q == lock_cmd_pkg::OP_CHIP_LOCK;
   assign m.rd_a_idx = addr_q[lock_cmd_pkg::BLOCK_HI:lock_cmd_pkg::BLOCK_LO];
   assign m.rd_b_idx = pe_addr[lock_cmd_pkg::BLOCK_HI:lock_cmd_pkg::BLOCK_LO];

   // Write latch: set by write enable, spent by any executed lock command.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wel_q <= 1'b0;
      end else if (wipe_q || block_go || chip_go) begin
         wel_q <= 1'b0;
      end else if (frame_end && boundary && byte_cnt_q == lock_cmd_pkg::CHIP_CMD_BYTES &&
                   cmd_q == lock_cmd_pkg::OP_WRITE_ENABLE) begin
         wel_q <= 1'b1;
      end
   end

   // Reset arm survives only until the next command, a no-operation included.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         arm_q <= 1'b0;
      end else if (wipe_q) begin
         arm_q <= 1'b0;
      end else if (frame_end && byte_cnt_q != 4'h0) begin
         arm_q <= boundary && byte_cnt_q == lock_cmd_pkg::CHIP_CMD_BYTES &&
                  cmd_q == lock_cmd_pkg::OP_RESET_ARM;
      end
   end

   // Reset pin must stay low a full minimum time before it counts.
   logic [PIN_CNT_W-1:0] pin_cnt_q;
   logic pin_hit;
   assign pin_hit = !pin_s && pin_cnt_q == PIN_CNT_LAST;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pin_cnt_q <= '0;
      end else if (pin_s) begin
         pin_cnt_q <= '0;
      end else if (pin_cnt_q != PIN_CNT_W'(lock_cmd_pkg::RESET_LOW_MIN_CYCLES)) begin
         pin_cnt_q <= PIN_CNT_W'(pin_cnt_q + 1'b1);
      end
   end

   // One wipe pulse for either reset source; busy work is told to abort.
   logic abort_q;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wipe_q <= 1'b0;
         abort_q <= 1'b0;
      end else begin
         wipe_q <= fire_go || pin_hit;
         abort_q <= (fire_go || pin_hit) && busy_flag;
      end
   end

   // Output shifter works on falling edges so data is stable at the host's rising edge.
   logic [3:0] out_start;
   logic out_phase;
   logic [2:0] out_cnt_q;
   logic [3:0] out_idx_q;
   logic [7:0] out_sh_q;
   logic [7:0] next_byte;
   logic [3:0] out_sum;
   logic [3:0] sio_out_q;
   logic [3:0] sio_oe_n_q;
   logic [7:0] cur;
   assign out_start = data_start(cmd_q);
   assign out_phase = frame && out_start != lock_cmd_pkg::NO_DATA_BYTE &&
                      byte_cnt_q >= out_start;
   assign out_sum = {1'b0, out_cnt_q} + step;
   always_comb begin
      case (cmd_q)
         lock_cmd_pkg::OP_LOCK_STATUS:
            next_byte = {lock_cmd_pkg::STATUS_PAD,
                         m.rd_a_data[addr_q[lock_cmd_pkg::SECTOR_HI:lock_cmd_pkg::SECTOR_LO]]};
         lock_cmd_pkg::OP_UNIQUE_ID:
            next_byte = UNIQUE_ID[{~out_idx_q, 3'h7} -: 8];
         default:
            next_byte = table_byte(8'(addr_q[7:0] + {4'h0, out_idx_q}));
      endcase
   end
   assign cur = (out_cnt_q == 3'h0) ? next_byte : out_sh_q;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         out_cnt_q <= 3'h0;
         out_idx_q <= 4'h0;
         out_sh_q <= 8'h00;
         sio_out_q <= 4'h0;
         sio_oe_n_q <= lock_cmd_pkg::OE_N_IDLE;
      end else if (wipe_q || !out_phase) begin
         out_cnt_q <= 3'h0;
         out_idx_q <= 4'h0;
         sio_oe_n_q <= lock_cmd_pkg::OE_N_IDLE;
      end else if (sck_fall) begin
         out_cnt_q <= out_sum[2:0];
         if (out_cnt_q == 3'h0) begin
            out_idx_q <= 4'(out_idx_q + 4'h1);
         end
         if (four_line_command_mode) begin
            sio_out_q <= cur[7:4];
            out_sh_q <= {cur[3:0], 4'h0};
            sio_oe_n_q <= lock_cmd_pkg::OE_N_QUAD;
         end else begin
            sio_out_q <= {2'b00, cur[7], 1'b0};
            out_sh_q <= {cur[6:0], 1'b0};
            sio_oe_n_q <= lock_cmd_pkg::OE_N_SINGLE;
         end
      end
   end

   // Program/erase gate: lock bit read one clock after the request.
   logic pe_stage_q;
   logic [3:0] pe_sector_q;
   logic [4:0] pe_block_q;
   logic pe_ack_q;
   logic pe_ok_q;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pe_stage_q <= 1'b0;
         pe_sector_q <= 4'h0;
         pe_block_q <= 5'h00;
         pe_ack_q <= 1'b0;
         pe_ok_q <= 1'b0;
      end else begin
         pe_stage_q <= pe_req;
         pe_ack_q <= pe_stage_q;
         if (pe_req) begin
            pe_sector_q <= pe_addr[lock_cmd_pkg::SECTOR_HI:lock_cmd_pkg::SECTOR_LO];
            pe_block_q <= pe_addr[lock_cmd_pkg::BLOCK_HI:lock_cmd_pkg::BLOCK_LO];
         end
         if (pe_stage_q) begin
            pe_ok_q <= protect_scheme_select ? !m.rd_b_data[pe_sector_q]
                       : !bp_protects(complement_protect_bit, block_protect_bits,
                                      pe_block_q);
         end
      end
   end

   assign sio_out = sio_out_q;
   assign sio_oe_n = sio_oe_n_q;
   assign pe_ack = pe_ack_q;
   assign pe_ok = pe_ok_q;
   assign write_latch_bit = wel_q;
   assign soft_reset = wipe_q;
   assign op_abort = abort_q;

   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   sequence frame_close_s;
      frame_end && boundary;
   endsequence

   sequence chip_cmd_s(logic [7:0] op);
      frame_close_s ##0 (wel_q && byte_cnt_q == 4'h1 && cmd_q == op);
   endsequence

   latch_needed_a: assert property ((m.wr_en || (m.fill_en && !wipe_q)) |-> wel_q)
      else $error("Lock state changed without write enable.");
   whole_byte_a: assert property (m.wr_en |-> (bit_cnt_q == 3'h0 && $rose(sync_q[5])))
      else $error("Lock write on a frame not ending at a byte boundary.");
   chip_lock_a: assert property (chip_cmd_s(8'h7e) |-> (m.fill_en && m.fill_val))
      else $error("Chip lock did not fill locked.");
   chip_unlock_a: assert property (chip_cmd_s(8'h98) |-> (m.fill_en && !m.fill_val))
      else $error("Chip unlock did not fill unlocked.");
   fire_needs_arm_a: assert property ((frame_close_s ##0 (cmd_q == 8'h99 && !arm_q))
      |=> !wipe_q)
      else $error("Reset fired without a preceding arm.");
   fire_resets_a: assert property (fire_go |=> (wipe_q ##1 (!wel_q && !arm_q)))
      else $error("Reset pair did not restore latch and arm.");
   pin_reset_a: assert property ($rose(wipe_q) && !$past(fire_go) |->
      ($past(pin_cnt_q) == PIN_CNT_LAST && !$past(pin_s)))
      else $error("Pin reset fired before the minimum low time.");
   float_pin_a: assert property (!pin_s |=> sio_oe_n == 4'hf)
      else $error("Data lines driven while the reset pin is low.");
   abort_busy_a: assert property ((pin_hit && busy_flag) |=> (op_abort ##1 !op_abort))
      else $error("Reset during busy did not abort for one clock.");
   lock_gate_a: assert property ((pe_stage_q && protect_scheme_select &&
      m.rd_b_data[pe_sector_q]) |=> (pe_ack && !pe_ok))
      else $error("Write allowed into a locked block.");

endmodule : flash_lock_cmd

// ==== tb/flash_host_model.sv ====
`timescale 1ns/100ps
// Behavioural host controller; the serial clock only runs inside a frame.
module flash_host_model (
   output logic sel_n,
   output logic sclk,
   output logic [3:0] sio,
   input wire logic [3:0] sio_out,
   input wire logic quad
);
   // Idle pins at time zero.
   initial begin
      sel_n = 1'b1;
      sclk = 1'b0;
      sio = 4'h5;
   end

   // The device syncs its select pin, so the first clock waits a little.
   task automatic open_frame();
      sel_n = 1'b0;
      #100;
   endtask : open_frame

   // Shifts n bits MSB first and samples just before each fall, when output is settled.
   task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
      int i;
      rx = 8'h00;
      for (i = 0; i < n; i += (quad ? 4 : 1)) begin
         sio = quad ? tx[7-i -: 4] : {~sio[3:1], tx[7-i]};
         #100;
         sclk = 1'b1;
         #100;
         rx = quad ? {rx[3:0], sio_out} : {rx[6:0], sio_out[1]};
         sclk = 1'b0;
      end
   endtask : shift

   // Unused lines flip so a stale value is never mistaken for data.
   task automatic close_frame();
      #100;
      sel_n = 1'b1;
      sio = ~sio;
      #1000;
   endtask : close_frame
endmodule : flash_host_model

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
   localparam logic [127:0] UID = 128'h5a5a_0f0f_1234_c3c3_8e71_0055_aa99_6b2d; // Arbitrary.
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic reset_n_pin = 1'b1;
   logic quad = 1'b0;
   logic pss = 1'b1;
   logic cmp = 1'b0;
   logic [4:0] bp = 5'h00;
   logic busy = 1'b0;
   logic pe_req = 1'b0;
   logic hold_sel = 1'b0;
   logic [20:0] pa = 21'h0;
   logic [20:0] a;
   logic sel_n, sclk, pe_ack, pe_ok, wlb, soft_reset, op_abort;
   logic [3:0] sio, sio_out, sio_oe_n;
   logic [7:0] rx;
   logic [127:0] got;
   int miscompares = 0;
   int n_tests = 0;
   int n_soft = 0;
   int n_abort = 0;
   int seed = 32'h192f;

   always #12.5 clk = ~clk;

   flash_lock_cmd #(.UNIQUE_ID(UID)) flash_lock_cmd_inst (.clk(clk), .reset(reset),
      .sel_n_pin(sel_n), .sclk_pin(sclk), .sio_in(sio), .reset_n_pin(reset_n_pin),
      .sio_out(sio_out), .sio_oe_n(sio_oe_n), .four_line_command_mode(quad),
      .protect_scheme_select(pss), .complement_protect_bit(cmp), .block_protect_bits(bp),
      .busy_flag(busy), .pe_req(pe_req), .pe_addr(pa), .pe_ack(pe_ack), .pe_ok(pe_ok),
      .write_latch_bit(wlb), .soft_reset(soft_reset), .op_abort(op_abort));

   flash_host_model flash_host_model_inst (.sel_n(sel_n), .sclk(sclk), .sio(sio),
      .sio_out(sio_out), .quad(quad));

   // Strobe pulses are counted so later checks can see how many fired.
   always @(posedge clk) begin
      n_soft += int'(soft_reset === 1'b1);
      n_abort += int'(op_abort === 1'b1);
   end

   task automatic check(input string what, input logic [127:0] exp, input logic [127:0] act);
      n_tests++;
      if (act !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, act);
      end
   endtask : check

   // One frame: opcode, nb payload bytes (the last cut to a bit count), nr bytes read.
   task automatic frame(input logic [7:0] op, input logic [31:0] pay, input int nb,
                        input int last, input int nr);
      int j;
      flash_host_model_inst.open_frame();
      flash_host_model_inst.shift(op, 8, rx);
      for (j = 0; j < nb; j++) begin
         flash_host_model_inst.shift(pay[31-8*j -: 8], (j == nb - 1) ? last : 8, rx);
      end
      for (j = 0; j < nr; j++) begin
         flash_host_model_inst.shift(8'h00, 8, rx);
         got = {got[119:0], rx};
      end
      if (hold_sel !== 1'b1) flash_host_model_inst.close_frame();
   endtask : frame

   task automatic stat(input logic [20:0] ad, input logic e);
      frame(8'h3d, {3'h0, ad, 8'h00}, 3, 8, 1);
      check("lock status", {7'h00, e}, got[7:0]);
   endtask : stat

   // The acknowledge stands for one cycle, one edge after the edge that takes the request.
   task automatic pe_check(input logic [20:0] ad, input logic e);
      @(posedge clk) #1;
      pe_req = 1'b1;
      pa = ad;
      @(posedge clk) #1;
      pe_req = 1'b0;
      @(posedge clk) #1;
      check("pe_ack", 1'b1, pe_ack);
      check("pe_ok", e, pe_ok);
   endtask : pe_check

   task automatic test_done();
      if (miscompares == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : test_done

   // Main sequence; a middle block is picked because edge blocks lock per sector.
   initial begin
      repeat (8) @(posedge clk);
      #1 reset = 1'b0;
      repeat (4) @(posedge clk);
      a = {5'(1 + ($unsigned($random(seed)) % 30)), 16'($random(seed))};
      stat(a, 1'b1);
      pe_check(a, 1'b0);
      frame(8'h39, {3'h0, a, 8'h00}, 3, 8, 0);
      stat(a, 1'b1);
      frame(8'h06, 32'h0, 0, 8, 0);
      check("write latch", 1'b1, wlb);
      frame(8'h98, 32'h0, 0, 8, 0);
      stat(a, 1'b0);
      pe_check(a, 1'b1);
      frame(8'h06, 32'h0, 0, 8, 0);
      frame(8'h36, {3'h0, a, 8'h00}, 3, 8, 0);
      stat(a, 1'b1);
      stat({a[20:16] ^ 5'h01, 16'h0}, 1'b0);
      @(posedge clk) #1;
      pss = 1'b0;
      bp = 5'h01;
      pe_check({5'h1f, 16'h0}, 1'b0);
      pe_check(a, 1'b1);
      @(posedge clk) #1;
      pss = 1'b1;
      frame(8'h06, 32'h0, 0, 8, 0);
      frame(8'h39, {3'h0, a, 8'h00}, 3, 5, 0);
      stat(a, 1'b1);
      frame(8'h06, 32'h0, 0, 8, 0);
      frame(8'h39, {3'h0, a, 8'h00}, 3, 8, 0);
      stat(a, 1'b0);
      @(posedge clk) #1;
      quad = 1'b1;
      frame(8'h06, 32'h0, 0, 8, 0);
      frame(8'h7e, 32'h0, 0, 8, 0);
      stat(a, 1'b1);
      @(posedge clk) #1;
      quad = 1'b0;
      frame(8'h4b, 32'h0, 4, 8, 16);
      check("unique id", UID, got);
      frame(8'h5a, 32'h0, 4, 8, 4);
      check("param table", 32'h53464450, got[31:0]);
      frame(8'h06, 32'h0, 0, 8, 0);
      frame(8'h98, 32'h0, 0, 8, 0);
      frame(8'h66, 32'h0, 0, 8, 0);
      frame(8'h00, 32'h0, 0, 8, 0);
      frame(8'h99, 32'h0, 0, 8, 0);
      check("soft reset count", 0, n_soft);
      @(posedge clk) #1;
      busy = 1'b1;
      frame(8'h66, 32'h0, 0, 8, 0);
      frame(8'h99, 32'h0, 0, 8, 0);
      check("soft reset count", 1, n_soft);
      check("abort count", 1, n_abort);
      @(posedge clk) #1;
      busy = 1'b0;
      stat(a, 1'b1);
      frame(8'h06, 32'h0, 0, 8, 0);
      frame(8'h98, 32'h0, 0, 8, 0);
      hold_sel = 1'b1;
      frame(8'h3d, {3'h0, a, 8'h00}, 3, 8, 1);
      @(posedge clk) #1;
      check("oe during read", 4'hd, sio_oe_n);
      busy = 1'b1;
      reset_n_pin = 1'b0;
      repeat (420) @(posedge clk);
      #1;
      check("oe during pin reset", 4'hf, sio_oe_n);
      flash_host_model_inst.close_frame();
      hold_sel = 1'b0;
      @(posedge clk) #1;
      reset_n_pin = 1'b1;
      busy = 1'b0;
      #30000;
      check("soft reset count", 2, n_soft);
      check("abort count", 2, n_abort);
      stat(a, 1'b1);
      test_done();
   end

   // Whole run needs well under half a millisecond of link traffic.
   initial begin
      #2000000;
      miscompares++;
      test_done();
   end
endmodule : tb_top
